// *** src/bstap_pkg.sv ***
package bstap_pkg;

	// ---------------------------------------------------------------
	// Instruction codes
	// ---------------------------------------------------------------
	localparam int          IR_W          = 16;              // Instruction register width
	localparam logic [15:0] OP_BYPASS0    = 16'h0000;        // Bypass, all zeros
	localparam logic [15:0] OP_BYPASS1    = 16'hffff;        // Bypass, all ones
	localparam logic [15:0] OP_SAMPLE     = 16'hfff8;        // Sample and preload
	localparam logic [15:0] OP_EXTEST     = 16'hffe8;        // External test
	localparam logic [15:0] OP_CLAMP      = 16'hffef;        // Clamp outputs
	localparam logic [15:0] OP_IDENT      = 16'hfffe;        // Identification
	localparam logic [15:0] OP_HIGHZ      = 16'hffcf;        // Outputs released
	localparam logic [15:0] OP_INTREG     = 16'hfffd;        // Private code, decodes to bypass
	localparam logic [15:0] IR_CAPTURE    = 16'h0001;        // Capture pattern, low bits 01
	localparam int          ID_W          = 32;              // Identification width
	localparam logic [31:0] ID_DEFAULT    = 32'h0abc_d001;   // Arbitrary value, bit 0 set
	localparam int          PINS_DEFAULT  = 8;               // Default scanned pin count

	// ---------------------------------------------------------------
	// Controller states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET  = 4'h0,
		ST_IDLE   = 4'h1,
		ST_SELDR  = 4'h2,
		ST_CAPDR  = 4'h3,
		ST_SHDR   = 4'h4,
		ST_EX1DR  = 4'h5,
		ST_PAUDR  = 4'h6,
		ST_EX2DR  = 4'h7,
		ST_UPDDR  = 4'h8,
		ST_SELIR  = 4'h9,
		ST_CAPIR  = 4'ha,
		ST_SHIR   = 4'hb,
		ST_EX1IR  = 4'hc,
		ST_PAUIR  = 4'hd,
		ST_EX2IR  = 4'he,
		ST_UPDIR  = 4'hf
	} bstap_state_e;

	// ---------------------------------------------------------------
	// Data register selection
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_BYP   = 2'h0,
		SEL_BSR   = 2'h1,
		SEL_ID    = 2'h2
	} bstap_sel_e;

	// Map an instruction to its data register
	function automatic bstap_sel_e bstap_decode(input logic [15:0] op);
		case (op)
			OP_SAMPLE, OP_EXTEST : bstap_decode = SEL_BSR;
			OP_IDENT             : bstap_decode = SEL_ID;
			default              : bstap_decode = SEL_BYP;
		endcase
	endfunction : bstap_decode

endpackage : bstap_pkg

// *** src/bstap_link_if.sv ***
`timescale 1ns/1ps
// Four-wire scan link between controller and device
interface bstap_link_if;
	logic testSel;   // Test-select pin, high puts shared pins in test role
	logic tck;       // Scan clock, made by the controller
	logic tms;       // Mode select
	logic tdi;       // Data toward the device
	logic tdo;       // Data from the device
	logic tdoOe;     // Device drives tdo while high

	modport dev  (input testSel, input tck, input tms, input tdi, output tdo, output tdoOe);
	modport ctrl (output testSel, output tck, output tms, output tdi, input tdo, input tdoOe);
endinterface : bstap_link_if

// *** src/bstap_sync.sv ***
`timescale 1ns/1ps
// Two flip-flop level synchroniser
module bstap_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;   // First stage, read only by second
	logic [W-1:0] meta_nxt;
	logic [W-1:0] dout_nxt;

	// ---------------------------------------------------------------
	// Next values
	// ---------------------------------------------------------------
	always_comb begin
		meta_nxt = rst ? '0 : din;
		dout_nxt = rst ? '0 : meta_r;
	end

	// Register stages
	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		dout   <= dout_nxt;
	end
endmodule : bstap_sync

// *** src/bstap_device.sv ***
`timescale 1ns/1ps
// How it works
// - Standard controller, instruction and data registers
// - Four link signals only, no reset pin
// - TMS and TDI sampled on rising edge
// - TDO changes on falling edge
// - Test role only while test-select asserted
// - All-zeros code selects bypass
// - All-ones code selects bypass
// - Sample/preload captures pins, preloads outputs
// - External test drives and captures pins
// - Clamp holds preloaded outputs, bypass selected
// - Identification code selects identification register
// - Highz releases outputs, bypass selected
// - Private code selects bypass
// - Fixed 32-bit identification value
// - Scan cell on each digital pin only
module bstap_device import bstap_pkg::*; #(
	parameter int          NPINS = PINS_DEFAULT,   // Digital pins with scan cells
	parameter logic [31:0] IDVAL = ID_DEFAULT      // Arbitrary identification value
) (
	bstap_link_if.dev          link,
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic [NPINS-1:0] coreOut,         // Functional output values
	input  wire logic [NPINS-1:0] coreOe,          // Functional output enables
	input  wire logic [NPINS-1:0] pinIn,           // Pad input levels
	output logic      [NPINS-1:0] pinOut,          // Pad output values
	output logic      [NPINS-1:0] pinOe,           // Pad output enables
	output logic      [NPINS-1:0] coreIn,          // Pad levels toward core
	output logic                  testActive       // Test role in force
);
	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	if (NPINS < 1) begin : g_chk
		$error("NPINS must be at least 1");
	end
	if (IDVAL[0] != 1'b1) begin : g_chk_id
		$error("IDVAL bit 0 must be one");
	end

	// ---------------------------------------------------------------
	// Link-clock state
	// ---------------------------------------------------------------
	localparam int BW = 2 * NPINS;                  // Cells: input, output value per pin
	bstap_state_e     st_r, st_nxt;                 // Controller state
	logic [IR_W-1:0]  irSh_r, irSh_nxt;             // Instruction shift stage
	logic [IR_W-1:0]  ir_r, ir_nxt;                 // Active instruction
	logic             byp_r, byp_nxt;               // Bypass bit
	logic [ID_W-1:0]  idSh_r, idSh_nxt;             // Identification shift
	logic [BW-1:0]    bsSh_r, bsSh_nxt;             // Boundary shift stage
	logic [BW-1:0]    bsUp_r, bsUp_nxt;             // Boundary update stage
	logic             tdo_r;                        // Falling-edge output
	logic             tdoOe_r;                      // Falling-edge enable
	logic             selSync;                      // Test-select, link domain
	logic             tdoBit;                       // Serial bit before retiming
	bstap_sel_e       sel;                          // Chosen data register

	// Select pin synchronised to the link clock, ahead of the controller
	bstap_sync #(.W(1)) u_selTck (
		.clk  (link.tck),
		.rst  (1'b0),
		.din  (link.testSel),
		.dout (selSync)
	);

	assign sel = bstap_decode(ir_r);

	// ---------------------------------------------------------------
	// Controller and register next values
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		irSh_nxt = irSh_r;
		ir_nxt   = ir_r;
		byp_nxt  = byp_r;
		idSh_nxt = idSh_r;
		bsSh_nxt = bsSh_r;
		bsUp_nxt = bsUp_r;
		// Standard sixteen-state walk
		case (st_r)
			ST_RESET : st_nxt = link.tms ? ST_RESET : ST_IDLE;
			ST_IDLE  : st_nxt = link.tms ? ST_SELDR : ST_IDLE;
			ST_SELDR : st_nxt = link.tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR : st_nxt = link.tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR  : st_nxt = link.tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR : st_nxt = link.tms ? ST_UPDDR : ST_PAUDR;
			ST_PAUDR : st_nxt = link.tms ? ST_EX2DR : ST_PAUDR;
			ST_EX2DR : st_nxt = link.tms ? ST_UPDDR : ST_SHDR;
			ST_UPDDR : st_nxt = link.tms ? ST_SELDR : ST_IDLE;
			ST_SELIR : st_nxt = link.tms ? ST_RESET : ST_CAPIR;
			ST_CAPIR : st_nxt = link.tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR  : st_nxt = link.tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR : st_nxt = link.tms ? ST_UPDIR : ST_PAUIR;
			ST_PAUIR : st_nxt = link.tms ? ST_EX2IR : ST_PAUIR;
			ST_EX2IR : st_nxt = link.tms ? ST_UPDIR : ST_SHIR;
			ST_UPDIR : st_nxt = link.tms ? ST_SELDR : ST_IDLE;
			default  : st_nxt = ST_RESET;
		endcase
		// Register actions of the current state
		case (st_r)
			ST_RESET : begin
				ir_nxt = OP_IDENT;
			end
			ST_CAPIR : begin
				irSh_nxt = IR_CAPTURE;
			end
			ST_SHIR : begin
				irSh_nxt = {link.tdi, irSh_r[IR_W-1:1]};
			end
			ST_UPDIR : begin
				ir_nxt = irSh_r;
			end
			ST_CAPDR : begin
				byp_nxt  = 1'b0;
				idSh_nxt = IDVAL;
				bsSh_nxt = {coreOut, pinIn};
			end
			ST_SHDR : begin
				byp_nxt  = link.tdi;
				idSh_nxt = {link.tdi, idSh_r[ID_W-1:1]};
				bsSh_nxt = {link.tdi, bsSh_r[BW-1:1]};
			end
			ST_UPDDR : begin
				if (sel == SEL_BSR) begin
					bsUp_nxt = bsSh_r;                  // Preload
				end
			end
			default : begin
			end
		endcase
		// Whole controller held in reset while the test role is off
		if (!selSync) begin
			st_nxt = ST_RESET;
		end
	end

	// Serial data out, by state and instruction
	always_comb begin
		if (st_r == ST_SHIR) begin
			tdoBit = irSh_r[0];
		end else begin
			case (sel)
				SEL_ID  : tdoBit = idSh_r[0];
				SEL_BSR : tdoBit = bsSh_r[0];
				default : tdoBit = byp_r;
			endcase
		end
	end

	// Rising-edge registers on the link clock
	always_ff @(posedge link.tck) begin
		st_r   <= st_nxt;
		irSh_r <= irSh_nxt;
		ir_r   <= ir_nxt;
		byp_r  <= byp_nxt;
		idSh_r <= idSh_nxt;
		bsSh_r <= bsSh_nxt;
		bsUp_r <= bsUp_nxt;
	end

	// Output retimed on the falling edge
	always_ff @(negedge link.tck) begin
		tdo_r   <= tdoBit;
		tdoOe_r <= (st_r == ST_SHIR) || (st_r == ST_SHDR);
	end

	assign link.tdo   = tdo_r;
	assign link.tdoOe = tdoOe_r;

	// ---------------------------------------------------------------
	// Pad multiplexing on the system clock
	// ---------------------------------------------------------------
	logic             selSys;                       // Test-select, system domain
	logic [15:0]      irSys;                        // Instruction, system domain
	logic [BW-1:0]    upSys;                        // Update stage, system domain
	logic [NPINS-1:0] pinOut_nxt, pinOe_nxt, coreIn_nxt;
	logic             act_nxt;

	// Quasi-static data: instruction and update stage change only at update states and in test-logic reset, test-select with its pin
	bstap_sync #(.W(1 + IR_W + BW)) u_toSys (
		.clk  (sys_clk),
		.rst  (srst),
		.din  ({link.testSel, ir_r, bsUp_r}),
		.dout ({selSys, irSys, upSys})
	);

	// Choose pad drive from instruction
	always_comb begin
		pinOut_nxt = coreOut;
		pinOe_nxt  = coreOe;
		coreIn_nxt = pinIn;
		act_nxt    = selSys;
		if (selSys) begin
			case (irSys)
				OP_EXTEST, OP_CLAMP : begin
					pinOut_nxt = upSys[BW-1:NPINS];
					pinOe_nxt  = '1;
				end
				OP_HIGHZ : begin
					pinOe_nxt  = '0;
				end
				default : begin
				end
			endcase
		end
		if (srst) begin
			pinOut_nxt = '0;
			pinOe_nxt  = '0;
			coreIn_nxt = '0;
			act_nxt    = 1'b0;
		end
	end

	// Pad registers
	always_ff @(posedge sys_clk) begin
		pinOut     <= pinOut_nxt;
		pinOe      <= pinOe_nxt;
		coreIn     <= coreIn_nxt;
		testActive <= act_nxt;
	end
endmodule : bstap_device

// *** src/bstap_ctrl.sv ***
`timescale 1ns/1ps
// Scan controller: one request shifts one register
module bstap_ctrl import bstap_pkg::*; #(
	parameter int DIV = 2,                          // Half-period of tck in sys_clk cycles
	parameter int LW  = 32                          // Max shift length
) (
	bstap_link_if.ctrl        link,
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          enable,              // Assert test-select
	input  wire logic          req,                 // Start a scan, one pulse
	input  wire logic          isIr,                // Scan instruction register
	input  wire logic [5:0]    len,                 // Bits to shift, 1..LW
	input  wire logic [LW-1:0] dIn,                 // Data, LSB first
	output logic               busy,                // Scan in progress
	output logic               done,                // One-cycle end pulse
	output logic      [LW-1:0] dOut                 // Captured bits, LSB at bit 0
);
	// tdo reaches the capture logic two cycles late, so a half period needs two cycles
	if (DIV < 2 || LW < 2 || LW > 63) begin : g_chk
		$error("bad DIV or LW");
	end

	// tms walk: 5 ones reset, then idle, select, (select-ir), capture, shift
	typedef enum logic [1:0] {C_IDLE = 2'h0, C_HEAD = 2'h1, C_SHIFT = 2'h2, C_TAIL = 2'h3} bstap_cst_e;
	bstap_cst_e     cs_r, cs_nxt;
	logic [7:0]     dv_r, dv_nxt;                   // Divider count
	logic           tck_r, tck_nxt;                 // Clock out
	logic [5:0]     n_r, n_nxt;                     // Step count
	logic [LW-1:0]  sh_r, sh_nxt;                   // Outgoing data
	logic [LW-1:0]  cap_r, cap_nxt;                 // Incoming data
	logic           tms_r, tms_nxt, tdi_r, tdi_nxt, ir_r, ir_nxt, sel_r, sel_nxt, done_nxt;
	logic [5:0]     len_r, len_nxt;
	logic           tdoS;                           // Synchronised tdo
	logic           fall;                           // Falling tck event this cycle

	bstap_sync #(.W(1)) u_tdo (.clk(sys_clk), .rst(srst), .din(link.tdo), .dout(tdoS));

	assign fall = (dv_r == 8'(DIV - 1)) && tck_r;

	always_comb begin
		cs_nxt = cs_r; dv_nxt = dv_r + 8'h01; tck_nxt = tck_r; n_nxt = n_r;
		sh_nxt = sh_r; cap_nxt = cap_r; tms_nxt = tms_r; tdi_nxt = tdi_r;
		ir_nxt = ir_r; len_nxt = len_r; sel_nxt = enable; done_nxt = 1'b0;
		if (dv_r == 8'(DIV - 1)) begin
			dv_nxt = 8'h00;
			tck_nxt = (cs_r != C_IDLE) ? !tck_r : 1'b0;
		end
		case (cs_r)
			C_IDLE : begin
				if (req && sel_r) begin                 // Only with test-select up
					cs_nxt = C_HEAD; n_nxt = 6'h00; sh_nxt = dIn; ir_nxt = isIr;
					len_nxt = len; tms_nxt = 1'b1; dv_nxt = 8'h00; tck_nxt = 1'b0;
				end
			end
			C_HEAD : if (fall) begin
				// Change tms on falling edge, device samples on rising
				n_nxt = n_r + 6'h01;
				case (n_r)
					6'h00, 6'h01, 6'h02, 6'h03 : tms_nxt = 1'b1;
					6'h04 : tms_nxt = 1'b0;
					6'h05 : tms_nxt = 1'b1;
					6'h06 : tms_nxt = ir_r;
					default : begin
						tms_nxt = 1'b0;
						// Leave the head on the fall just before the first shifting rise
						if (n_r == (ir_r ? 6'h09 : 6'h08)) begin
							cs_nxt = C_SHIFT; n_nxt = 6'h00; tdi_nxt = sh_r[0];
							tms_nxt = (len_r == 6'h01);
						end
					end
				endcase
			end
			C_SHIFT : begin
				if (fall) begin
					// Bit of the rise just passed; tdoS lags tdo by two cycles
					cap_nxt = {tdoS, cap_r[LW-1:1]};
					n_nxt = n_r + 6'h01;
					sh_nxt = {1'b0, sh_r[LW-1:1]};
					tdi_nxt = sh_r[1];
					tms_nxt = (n_r + 6'h02 >= len_r);       // Last bit leaves shift
					if (n_r + 6'h01 >= len_r) begin
						cs_nxt = C_TAIL;
						n_nxt = 6'h00;
						tms_nxt = 1'b1;
					end
				end
			end
			C_TAIL : if (fall) begin
				n_nxt = n_r + 6'h01; tms_nxt = 1'b0;
				if (n_r == 6'h01) begin
					cs_nxt = C_IDLE;
					done_nxt = 1'b1;
					tms_nxt = 1'b1;                         // Park high on a fall, next head needs no edge
					cap_nxt = cap_r >> (6'(LW) - len_r);
				end
			end
			default : cs_nxt = C_IDLE;
		endcase
		if (srst) begin
			cs_nxt = C_IDLE; dv_nxt = 8'h00; tck_nxt = 1'b0; tms_nxt = 1'b1; tdi_nxt = 1'b0;
			sel_nxt = 1'b0; done_nxt = 1'b0; cap_nxt = '0; n_nxt = 6'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		cs_r <= cs_nxt; dv_r <= dv_nxt; tck_r <= tck_nxt; n_r <= n_nxt; sh_r <= sh_nxt;
		cap_r <= cap_nxt; tms_r <= tms_nxt; tdi_r <= tdi_nxt; ir_r <= ir_nxt;
		len_r <= len_nxt; sel_r <= sel_nxt; done <= done_nxt;
		busy  <= (cs_nxt != C_IDLE);
	end

	assign link.tck = tck_r; assign link.tms = tms_r; assign link.tdi = tdi_r;
	assign link.testSel = sel_r;
	assign dOut = cap_r;
endmodule : bstap_ctrl

// *** sim/bstap_props.sv ***
`timescale 1ns/1ps
// Link-side checks for the four-wire scan link
module bstap_props #(
	parameter int DIV = 2                     // Half-period of tck in sys_clk cycles
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic testSel,
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	input  wire logic tdo,
	input  wire logic tdoOe
);
	// ---------------------------------------------------------------
	// Helper counters
	// ---------------------------------------------------------------
	logic [7:0] loCnt_r, loCnt_nxt;           // Low samples of tck, saturating
	logic [7:0] hiCnt_r, hiCnt_nxt;           // High samples of tck, saturating
	logic [5:0] riseCnt_r, riseCnt_nxt;       // Rises since the link went idle
	logic       tckQ_r, tckQ_nxt;             // Previous tck sample
	logic       idle;                         // Low beyond a half period: between frames

	// Next values of the counters
	always_comb begin
		idle = (loCnt_r > 8'(DIV));
		tckQ_nxt = tck;
		loCnt_nxt = tck ? 8'h00 : ((loCnt_r == 8'hff) ? loCnt_r : loCnt_r + 8'h01);
		hiCnt_nxt = !tck ? 8'h00 : ((hiCnt_r == 8'hff) ? hiCnt_r : hiCnt_r + 8'h01);
		riseCnt_nxt = idle ? 6'h00 : riseCnt_r;
		if (tck && !tckQ_r) begin        // First rise after idle counts as one
			riseCnt_nxt = idle ? 6'h01 : ((riseCnt_r == 6'h3f) ? riseCnt_r : riseCnt_r + 6'h01);
		end
	end

	// Register the counters
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			loCnt_r <= 8'hff;
			hiCnt_r <= 8'h00;
			riseCnt_r <= 6'h00;
			tckQ_r <= 1'b0;
		end else begin
			loCnt_r <= loCnt_nxt;
			hiCnt_r <= hiCnt_nxt;
			riseCnt_r <= riseCnt_nxt;
			tckQ_r <= tckQ_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_tckHigh; $fell(tck) |-> hiCnt_r == 8'(DIV); endproperty
	property p_tckLow; $rose(tck) |-> (loCnt_r == 8'(DIV)) || idle; endproperty
	property p_inOnFall; testSel && $past(testSel) && $changed({tms, tdi}) |-> $fell(tck); endproperty
	property p_tdoOnFall; tdoOe && $past(tdoOe) && $changed(tdo) |-> $fell(tck); endproperty
	property p_tdoHighStable; tck && tdoOe && $past(tdoOe) |-> $stable(tdo); endproperty
	property p_headOnes; $rose(tck) && (riseCnt_r < 6'h05) |-> tms; endproperty
	property p_headIdle; $rose(tck) && (riseCnt_r == 6'h05) |-> !tms; endproperty
	property p_selectDr; $rose(tck) && (riseCnt_r == 6'h06) |-> tms ##1 !tdoOe; endproperty
	property p_oeQuiet; $rose(tck) && (riseCnt_r inside {[6'h05:6'h07]}) |-> !tdoOe; endproperty

	a_tckHigh: assert property (p_tckHigh) else $error("tck high phase has wrong length");
	a_tckLow: assert property (p_tckLow) else $error("tck low phase has wrong length");
	a_inOnFall: assert property (p_inOnFall) else $error("tms or tdi moved off a falling tck");
	a_tdoOnFall: assert property (p_tdoOnFall) else $error("tdo moved off a falling tck");
	a_tdoHighStable: assert property (p_tdoHighStable) else $error("tdo moved while tck high");
	a_headOnes: assert property (p_headOnes) else $error("scan head lacks five tms ones");
	a_headIdle: assert property (p_headIdle) else $error("scan head skips idle state");
	a_selectDr: assert property (p_selectDr) else $error("scan head skips select state");
	a_oeQuiet: assert property (p_oeQuiet) else $error("tdo driven outside shift");

	c_enable: cover property ($rose(testSel));
	c_irPath: cover property ($rose(tck) && (riseCnt_r == 6'h07) && tms);
	c_shift: cover property ($rose(tdoOe));
endmodule : bstap_props

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// Scan controller and device joined across the four-wire link
module testbench import bstap_pkg::*;;
	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	localparam int          LIMIT = 20000;   // Cycle ceiling for the whole run
	localparam logic [15:0] CODES [10] = '{OP_BYPASS0, OP_BYPASS1, OP_SAMPLE, OP_EXTEST, OP_CLAMP,
		OP_IDENT, OP_HIGHZ, OP_INTREG, 16'h1234, 16'hfff0};   // Listed and unlisted codes
	logic        sys_clk = 1'b0;
	logic        srst    = 1'b1;
	logic        enable  = 1'b0;
	logic        req     = 1'b0;
	logic        isIr    = 1'b0;
	logic [5:0]  len     = 6'h20;
	logic [31:0] dIn     = 32'h0000_0000;
	logic [7:0]  coreOut = 8'ha5;
	logic [7:0]  coreOe  = 8'h3c;
	logic [7:0]  pinIn   = 8'h96;
	logic        busy, done, testActive;
	logic [31:0] dOut;
	logic [7:0]  pinOut, pinOe, coreIn;
	int          failures = 0;
	int          compares = 0;
	int          cycles   = 0;

	bstap_link_if link ();   // The four-wire link

	bstap_ctrl #(.DIV(2), .LW(32)) i_bstap_ctrl (.link(link.ctrl), .sys_clk(sys_clk), .srst(srst),
		.enable(enable), .req(req), .isIr(isIr), .len(len), .dIn(dIn), .busy(busy), .done(done), .dOut(dOut));
	bstap_device #(.NPINS(8)) i_bstap_device (.link(link.dev), .sys_clk(sys_clk), .srst(srst),
		.coreOut(coreOut), .coreOe(coreOe), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.coreIn(coreIn), .testActive(testActive));
	bstap_props #(.DIV(2)) i_bstap_props (.sys_clk(sys_clk), .srst(srst), .testSel(link.testSel),
		.tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdoOe(link.tdoOe));

	// ---------------------------------------------------------------
	// Clock and hang guard
	// ---------------------------------------------------------------
	always #50 sys_clk = ~sys_clk;

	// Count cycles, give up at the ceiling
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			summarize();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	// Compare one value and count it
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One scan request pulse, then wait for the end pulse
	task automatic scan(input logic ir, input logic [5:0] n, input logic [31:0] d);
		int k;
		@(negedge sys_clk);
		isIr = ir;
		len = n;
		dIn = d;
		req = 1'b1;
		@(negedge sys_clk);
		req = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 1000) begin
			@(negedge sys_clk);
			k++;
		end
		check("done", {31'h0, done}, 32'h1);
	endtask : scan

	// Let pad state cross into the system domain
	task automatic settle;
		repeat (20) @(negedge sys_clk);
	endtask : settle

	// Pads carry the functional values
	task automatic pinsFollow;
		check("pinOut", {24'h0, pinOut}, {24'h0, coreOut});
		check("pinOe", {24'h0, pinOe}, {24'h0, coreOe});
		check("coreIn", {24'h0, coreIn}, {24'h0, pinIn});
	endtask : pinsFollow

	// Verdict and end of run
	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		enable = 1'b1;
		repeat (4) @(negedge sys_clk);
		// Default instruction after reset shifts the identification value
		scan(1'b0, 6'h20, 32'h0000_0000);
		check("idFull", dOut, ID_DEFAULT);
		check("active", {31'h0, testActive}, 32'h1);
		settle();
		pinsFollow();
		scan(1'b0, 6'h08, 32'h0000_00ff);
		check("idLow", {24'h0, dOut[7:0]}, {24'h0, ID_DEFAULT[7:0]});
		$display("test identification done");
		// Every instruction code, capture pattern and pad effect
		foreach (CODES[i]) begin
			scan(1'b1, 6'h10, {16'h0, CODES[i]});
			check("irCapture", {16'h0, dOut[15:0]}, {16'h0, IR_CAPTURE});
			settle();
			check("activeIr", {31'h0, testActive}, 32'h1);
			if (CODES[i] == OP_HIGHZ) begin
				check("pinOeHighz", {24'h0, pinOe}, 32'h0);
			end else if (CODES[i] inside {OP_EXTEST, OP_CLAMP}) begin
				check("pinOeDrive", {24'h0, pinOe}, 32'h0000_00ff);
			end else begin
				pinsFollow();
			end
		end
		$display("test instruction codes done");
		// Release then identification again on the next request
		scan(1'b1, 6'h10, {16'h0, OP_HIGHZ});
		scan(1'b0, 6'h20, 32'h0000_0000);
		check("idAgain", dOut, ID_DEFAULT);
		settle();
		pinsFollow();
		$display("test back to back done");
		// Test role dropped: pads functional, requests ignored
		coreOut = 8'h5a;
		coreOe = 8'hc3;
		pinIn = 8'h69;
		enable = 1'b0;
		settle();
		check("inactive", {31'h0, testActive}, 32'h0);
		pinsFollow();
		req = 1'b1;
		@(negedge sys_clk);
		req = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("busyOff", {31'h0, busy}, 32'h0);
		enable = 1'b1;
		repeat (4) @(negedge sys_clk);
		scan(1'b0, 6'h20, 32'h0000_0000);
		check("idReenable", dOut, ID_DEFAULT);
		$display("test select pin done");
		summarize();
	end
endmodule : testbench
